// ===== rtl/mbf_pkg.sv
// Shared constants for the MODBUS slave framer.
package mbf_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned BAUD_BASE_BPS = 4800;
	localparam int unsigned BIT_CYC_BASE  = CLK_HZ / BAUD_BASE_BPS;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned MS_CYC        = CLK_HZ / MS_PER_S;
	localparam logic [4:0]  GAP_BASE_MS   = 5'h10;

	// ----------------------------------------------------------------
	// Setting encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] PROTO_VENDOR = 2'h0;
	localparam logic [1:0] PROTO_ASCII  = 2'h1;
	localparam logic [1:0] PROTO_RTU    = 2'h2;
	localparam logic       LEN_8        = 1'h1;
	localparam logic [1:0] PAR_EVEN     = 2'h0;
	localparam logic [1:0] PAR_ODD      = 2'h1;
	localparam logic [1:0] PAR_NONE     = 2'h2;
	localparam logic       STOP_2       = 1'h1;
	localparam logic [7:0] DLY_MIN_MS   = 8'h01;
	localparam logic [7:0] DLY_MAX_MS   = 8'hFA;
	localparam logic [7:0] DLY_DFLT_MS  = 8'h03;
	localparam logic [6:0] STATION_OFF  = 7'h00;
	localparam int unsigned MAX_SLAVES  = 31;

	// ----------------------------------------------------------------
	// Characters, check values and reset levels
	// ----------------------------------------------------------------
	localparam logic [7:0]  CHR_COLON = 8'h3A;
	localparam logic [7:0]  CHR_CR    = 8'h0D;
	localparam logic [7:0]  CHR_LF    = 8'h0A;
	localparam logic [7:0]  CHR_0     = 8'h30;
	localparam logic [7:0]  CHR_9     = 8'h39;
	localparam logic [7:0]  CHR_A     = 8'h41;
	localparam logic [7:0]  CHR_F     = 8'h46;
	localparam logic [15:0] CRC_INIT  = 16'hFFFF;
	localparam logic [15:0] CRC_POLY  = 16'hA001;
	localparam logic [15:0] CRC_GOOD  = 16'h0000;
	localparam logic [7:0]  LRC_GOOD  = 8'h00;
	localparam logic        LINE_IDLE = 1'h1;
	localparam int unsigned RPL_W     = 9;
	localparam int unsigned RPL_DEPTH = 2;

endpackage

// ===== rtl/mbf_buf.sv
// Small valid/ready buffer for reply bytes.
`timescale 1ns/1ps
`default_nettype none
module mbf_buf
	import mbf_pkg::*;
#(
	parameter int unsigned W = RPL_W,
	parameter int unsigned D = RPL_DEPTH
)(
	input  wire logic         mclk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] in_data_in,
	input  wire logic         in_valid_in,
	output logic              in_ready_out,
	output logic [W-1:0]      out_data_out,
	output logic              out_valid_out,
	input  wire logic         out_ready_in
);
	localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0]  mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          rdy_r;

	function automatic logic [AW-1:0] adv(input logic [AW-1:0] p);
		return (p == AW'(D - 1)) ? '0 : p + 1'b1;
	endfunction

	wire           wr      = in_valid_in && rdy_r;
	wire           rd      = out_ready_in && (cnt_r != '0);
	wire [AW:0]    cnt_nxt = cnt_r + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};

	assign in_ready_out  = rdy_r;
	assign out_valid_out = (cnt_r != '0);
	assign out_data_out  = mem_r[rp_r];

	// Ready is registered from the next count, so the writer is stalled exactly while the buffer is full, never late.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b1;
		end else begin
			if (wr) wp_r <= adv(wp_r);
			if (rd) rp_r <= adv(rp_r);
			cnt_r <= cnt_nxt;
			rdy_r <= (cnt_nxt != (AW + 1)'(D));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (wr) mem_r[wp_r] <= in_data_in;
	end
endmodule
`default_nettype wire

// ===== rtl/mbf_uart.sv
// Asynchronous character receiver and transmitter for the framer.
`timescale 1ns/1ps
`default_nettype none
module mbf_uart
	import mbf_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	input  wire logic        rxd_in,
	input  wire logic [13:0] bit_cyc_in,
	input  wire logic        bits8_in,
	input  wire logic [1:0]  par_in,
	input  wire logic        stop2_in,
	output logic [7:0]       rx_byte_out,
	output logic             rx_stb_out,
	output logic             rx_err_out,
	input  wire logic [7:0]  tx_byte_in,
	input  wire logic        tx_go_in,
	output logic             tx_busy_out,
	output logic             txd_out
);
	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	logic        s1_r;
	logic        s2_r;
	logic        ract_r;
	logic [13:0] rcnt_r;
	logic [3:0]  ridx_r;
	logic [9:0]  rsh_r;

	wire       par_on = (par_in != PAR_NONE);
	wire [3:0] rlen   = 4'h8 + {3'h0, bits8_in} + {3'h0, par_on};
	wire       rdue   = ract_r && (rcnt_r == 14'h0000);
	wire [7:0] rdat   = bits8_in ? rsh_r[7:0] : {1'b0, rsh_r[6:0]};
	wire       rpb    = bits8_in ? rsh_r[8] : rsh_r[7];
	wire       rperr  = par_on && ((^rdat ^ rpb) != (par_in == PAR_ODD)); // [R6]
	wire       rlast  = rdue && (ridx_r == rlen);

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_r   <= LINE_IDLE;
			s2_r   <= LINE_IDLE;
			ract_r <= 1'b0;
			rcnt_r <= '0;
			ridx_r <= '0;
			rsh_r  <= '0;
		end else begin
			s1_r <= rxd_in;
			s2_r <= s1_r;
			if (!ract_r) begin
				if (!s2_r) begin
					ract_r <= 1'b1;
					rcnt_r <= bit_cyc_in >> 1;
					ridx_r <= '0;
				end
			end else if (rdue) begin
				rcnt_r <= bit_cyc_in - 14'h0001;
				ridx_r <= ridx_r + 4'h1;
				if ((ridx_r == 4'h0 && s2_r) || rlast) ract_r <= 1'b0;
				else if (ridx_r != 4'h0) rsh_r[ridx_r - 4'h1] <= s2_r;
			end else begin
				rcnt_r <= rcnt_r - 14'h0001;
			end
		end
	end

	// A missing stop bit or a parity mismatch is reported with the byte.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_stb_out  <= 1'b0;
			rx_byte_out <= '0;
			rx_err_out  <= 1'b0;
		end else begin
			rx_stb_out <= rlast;
			if (rlast) begin
				rx_byte_out <= rdat;
				rx_err_out  <= rperr || !s2_r; // [R28]
			end
		end
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	logic [11:0] tsh_r;
	logic [3:0]  tleft_r;
	logic [13:0] tcnt_r;

	wire [7:0]  tdat = bits8_in ? tx_byte_in : {1'b0, tx_byte_in[6:0]};
	wire        tpb  = par_on ? (^tdat ^ (par_in == PAR_ODD)) : LINE_IDLE; // [R6]
	wire [11:0] tw   = bits8_in ? {2'b11, tpb, tdat, 1'b0} : {3'b111, tpb, tdat[6:0], 1'b0};
	wire [3:0]  tlen = 4'h9 + {3'h0, bits8_in} + {3'h0, par_on} + {3'h0, stop2_in == STOP_2}; // [R7]

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			txd_out     <= LINE_IDLE;
			tx_busy_out <= 1'b0;
			tsh_r       <= '0;
			tleft_r     <= '0;
			tcnt_r      <= '0;
		end else if (tx_go_in && !tx_busy_out) begin
			tx_busy_out <= 1'b1;
			txd_out     <= tw[0];
			tsh_r       <= tw >> 1;
			tleft_r     <= tlen - 4'h1;
			tcnt_r      <= bit_cyc_in - 14'h0001;
		end else if (tx_busy_out) begin
			if (tcnt_r != 14'h0000) begin
				tcnt_r <= tcnt_r - 14'h0001;
			end else if (tleft_r == 4'h0) begin
				tx_busy_out <= 1'b0;
			end else begin
				txd_out <= tsh_r[0];
				tsh_r   <= tsh_r >> 1;
				tleft_r <= tleft_r - 4'h1;
				tcnt_r  <= bit_cyc_in - 14'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ===== rtl/mbf_framer.sv
// MODBUS slave message framer: ASCII and RTU receive, address filter and reply.
//
// Function
// [R1] Protocol code 0 vendor link, 1 ASCII framing, 2 RTU framing; on code 0 the framer has no vendor link and stays inert.
// [R2] Station number 1 to 127; zero disables all replies.
// [R3] Baud code 0..3 selects 4800, 9600, 19200, 38400 bit/s.
// [R4] Length code 0 gives 7-bit characters, code 1 gives 8-bit.
// [R5] RTU framing always uses 8-bit characters.
// [R6] Parity code 0 even, 1 odd, 2 no parity bit.
// [R7] Stop code 0 one stop bit, 1 two stop bits when sending.
// [R8] Reply delay 1 to 250 ms, default 3.
// [R9] Settings come only from the console side, never from the line.
// [R10] One request goes to one slave, which answers once.
// [R11] ASCII frame: colon, two hex address chars, payload, hex LRC, CR LF.
// [R12] ASCII colon in any state restarts reception with that colon.
// [R13] Reply only when the received station equals our own.
// [R14] Station zero never replies, even on a matching address.
// [R15] The reply carries the station number as received.
// [R16] LRC: two's complement of the byte sum, address to payload end.
// [R17] ASCII frame completes on LF and is then handed on.
// [R18] RTU frame: one address byte, binary payload, two CRC bytes.
// [R19] CRC-16 from 0xFFFF, reflected polynomial 0xA001, byte-wise.
// [R20] CRC low byte goes on the line first.
// [R21] RTU frame ends after 16, 8, 4 or 2 ms of silence.
// [R22] The master never mixes protocols on one line.
// [R23] Up to 31 slaves share one master.
// [R24] Driver stays off for at least the reply delay after a request.
// [R25] The master waits 10 ms after a reply before its next request.
// [R26] The master times out after two seconds and retries twice.
// [R27] A frame with a bad LRC or CRC is dropped silently.
// [R28] A parity or framing error drops the whole frame; an error on the closing LF of an ASCII frame does not.
`timescale 1ns/1ps
`default_nettype none
module mbf_framer
	import mbf_pkg::*;
#(
	parameter int unsigned P_BIT_CYC = BIT_CYC_BASE,
	parameter int unsigned P_MS_CYC  = MS_CYC
)(
	input  wire logic       mclk_in,
	input  wire logic       rstn_in,
	input  wire logic       rxd_in,
	output logic            txd_out,
	output logic            de_out,
	input  wire logic [1:0] proto_in,
	input  wire logic [6:0] station_number_setting_in,
	input  wire logic [1:0] baud_in,
	input  wire logic       len_in,
	input  wire logic [1:0] parity_in,
	input  wire logic       stop_in,
	input  wire logic [7:0] reply_delay_setting_in,
	output logic [7:0]      pay_byte_out,
	output logic            pay_valid_out,
	output logic            frame_ok_out,
	output logic            frame_drop_out,
	input  wire logic [7:0] rep_byte_in,
	input  wire logic       rep_last_in,
	input  wire logic       rep_valid_in,
	output logic            rep_ready_out
);
	typedef enum logic [2:0] {RX_IDLE, RX_AHI, RX_ALO, RX_DHI, RX_DLO, RX_LF, RX_RDAT} mbf_rx_t;
	typedef enum logic [3:0] {
		TX_IDLE, TX_WAIT, TX_SOF, TX_AHI, TX_ALO, TX_DHI,
		TX_DLO, TX_CHI, TX_CLO, TX_CR, TX_LF, TX_END
	} mbf_tx_t;

	// ----------------------------------------------------------------
	// Character helpers
	// ----------------------------------------------------------------
	function automatic logic [4:0] hex_dec(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h00;
		if (c >= CHR_0 && c <= CHR_9) r = {1'b1, c[3:0]};
		else if (c >= CHR_A && c <= CHR_F) r = {1'b1, c[3:0] + 4'h9};
		return r;
	endfunction

	function automatic logic [7:0] hex_enc(input logic [3:0] n);
		return (n < 4'hA) ? CHR_0 + {4'h0, n} : CHR_A + {4'h0, n - 4'hA};
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1); // [R19]
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------
	// The settings are plain ports owned by the console side; nothing received can alter them.
	wire        is_asc  = (proto_in == PROTO_ASCII); // [R1] [R9]
	wire        is_rtu  = (proto_in == PROTO_RTU); // [R1]
	wire        active  = is_asc || is_rtu; // [R1]
	wire        bits8   = is_rtu || (len_in == LEN_8); // [R4] [R5]
	wire [13:0] bit_cyc = 14'(P_BIT_CYC >> baud_in); // [R3]
	wire [4:0]  gap_lim = GAP_BASE_MS >> baud_in; // [R21]
	wire        st_on   = (station_number_setting_in != STATION_OFF); // [R2] [R14]
	wire [7:0]  dly_eff = (reply_delay_setting_in < DLY_MIN_MS) ? DLY_MIN_MS :
		(reply_delay_setting_in > DLY_MAX_MS) ? DLY_MAX_MS : reply_delay_setting_in; // [R8]

	// ----------------------------------------------------------------
	// Line engine and reply buffer
	// ----------------------------------------------------------------
	logic [7:0] rx_byte;
	logic       rx_stb;
	logic       rx_err;
	logic       u_busy;
	logic       go_r;
	logic [7:0] chr_r;
	logic [7:0] buf_b;
	logic       buf_last;
	logic       buf_v;
	logic       pop;

	mbf_uart u_uart (
		.mclk_in     (mclk_in),
		.rstn_in     (rstn_in),
		.rxd_in      (rxd_in),
		.bit_cyc_in  (bit_cyc),
		.bits8_in    (bits8),
		.par_in      (parity_in),
		.stop2_in    (stop_in),
		.rx_byte_out (rx_byte),
		.rx_stb_out  (rx_stb),
		.rx_err_out  (rx_err),
		.tx_byte_in  (chr_r),
		.tx_go_in    (go_r),
		.tx_busy_out (u_busy),
		.txd_out     (txd_out)
	);

	// Reply bytes wait here while the turnaround delay runs; a full buffer stalls the source.
	mbf_buf #(
		.W (RPL_W),
		.D (RPL_DEPTH)
	) u_buf (
		.mclk_in       (mclk_in),
		.rstn_in       (rstn_in),
		.in_data_in    ({rep_last_in, rep_byte_in}),
		.in_valid_in   (rep_valid_in),
		.in_ready_out  (rep_ready_out),
		.out_data_out  ({buf_last, buf_b}),
		.out_valid_out (buf_v),
		.out_ready_in  (pop)
	);

	// ----------------------------------------------------------------
	// Millisecond timebase and silence timer
	// ----------------------------------------------------------------
	logic [15:0] ms_cnt_r;
	logic [4:0]  gap_r;
	logic        good;
	mbf_rx_t     rx_st_r;
	mbf_rx_t     rx_st_nxt;
	mbf_tx_t     tx_st_r;
	mbf_tx_t     tx_nxt;

	wire ms_tick = (ms_cnt_r == 16'(P_MS_CYC - 1));

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ms_cnt_r <= '0;
			gap_r    <= '0;
		end else begin
			ms_cnt_r <= (rx_stb || good || ms_tick) ? 16'h0000 : ms_cnt_r + 16'h0001;
			if (rx_stb) gap_r <= '0;
			else if (ms_tick) gap_r <= gap_r + 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// Receive framing
	// ----------------------------------------------------------------
	logic [7:0]  addr_r;
	logic [3:0]  nib_r;
	logic [7:0]  lrc_r;
	logic [15:0] crc_r;
	logic        bad_r;
	logic [1:0]  pv_r;
	logic [7:0]  p0_r;
	logic [7:0]  p1_r;

	// The line is half duplex, so nothing is taken while a reply is pending or going out.
	wire       rx_take   = rx_stb && active && (tx_st_r == TX_IDLE); // [R10]
	wire [4:0] hx        = hex_dec(rx_byte);
	wire       hok       = hx[4];
	wire       colon     = rx_take && is_asc && (rx_byte == CHR_COLON); // [R12]
	wire       asc_st    = rx_take && is_asc && !colon;
	wire [7:0] pair_b    = {nib_r, hx[3:0]};
	wire       nib_ld    = asc_st && hok && (rx_st_r == RX_AHI || rx_st_r == RX_DHI);
	wire       addr_ld_a = asc_st && hok && (rx_st_r == RX_ALO); // [R11]
	wire       rtu_first = rx_take && is_rtu && (rx_st_r == RX_IDLE); // [R18]
	wire       push_asc  = asc_st && hok && (rx_st_r == RX_DLO);
	wire       push_rtu  = rx_take && is_rtu && (rx_st_r == RX_RDAT); // [R18]
	wire       push      = push_asc || push_rtu;
	wire [7:0] push_b    = is_rtu ? rx_byte : pair_b;
	// The check bytes trail the payload, so one byte (ASCII) or two (RTU) are held back.
	wire       pipe_full = is_rtu ? (pv_r == 2'h2) : (pv_r == 2'h1);
	wire [7:0] emit_b    = is_rtu ? p1_r : p0_r;
	wire       addr_ok   = st_on && (addr_r == {1'b0, station_number_setting_in}); // [R13] [R14] [R23]
	wire       end_asc   = asc_st && (rx_st_r == RX_LF) && (rx_byte == CHR_LF); // [R17]
	wire       end_rtu   = is_rtu && (rx_st_r == RX_RDAT) && ms_tick && !rx_stb &&
		(gap_r == gap_lim - 5'h01); // [R21]
	wire       frame_end = end_asc || end_rtu;
	wire       sum_ok    = is_rtu ? (crc_r == CRC_GOOD) : (lrc_r == LRC_GOOD); // [R16] [R20]

	assign good = frame_end && !bad_r && sum_ok && pipe_full && addr_ok; // [R27] [R28]

	always_comb begin
		rx_st_nxt = rx_st_r;
		if (!active) begin
			rx_st_nxt = RX_IDLE;
		end else if (colon) begin
			rx_st_nxt = RX_AHI; // [R12]
		end else if (rx_take) begin
			case (rx_st_r)
				RX_IDLE: rx_st_nxt = is_rtu ? RX_RDAT : RX_IDLE;
				RX_AHI:  rx_st_nxt = hok ? RX_ALO : RX_IDLE;
				RX_ALO:  rx_st_nxt = hok ? RX_DHI : RX_IDLE;
				RX_DHI:  rx_st_nxt = (rx_byte == CHR_CR) ? RX_LF : (hok ? RX_DLO : RX_IDLE);
				RX_DLO:  rx_st_nxt = hok ? RX_DHI : RX_IDLE;
				RX_LF:   rx_st_nxt = RX_IDLE;
				RX_RDAT: rx_st_nxt = RX_RDAT;
				default: rx_st_nxt = RX_IDLE;
			endcase
		end else if (end_rtu) begin
			rx_st_nxt = RX_IDLE;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) rx_st_r <= RX_IDLE;
		else rx_st_r <= rx_st_nxt;
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_r <= '0;
			nib_r  <= '0;
			lrc_r  <= '0;
			crc_r  <= CRC_INIT;
		end else begin
			if (nib_ld) nib_r <= hx[3:0];
			if (addr_ld_a) addr_r <= pair_b; // [R15]
			else if (rtu_first) addr_r <= rx_byte; // [R15]
			if (colon) lrc_r <= LRC_GOOD;
			else if (addr_ld_a || push_asc) lrc_r <= lrc_r + pair_b; // [R16]
			if (rtu_first) crc_r <= crc_step(CRC_INIT, rx_byte); // [R19]
			else if (push_rtu) crc_r <= crc_step(crc_r, rx_byte); // [R19]
		end
	end

	// Any damaged character but the closing LF of an ASCII frame spoils the frame; a restart reloads the mark from the error flag of its first character.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) bad_r <= 1'b0;
		else if (colon || rtu_first) bad_r <= rx_err; // [R28]
		else if (rx_take && rx_err) bad_r <= 1'b1; // [R28]
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pv_r <= '0;
			p0_r <= '0;
			p1_r <= '0;
		end else if (colon || rtu_first) begin
			pv_r <= '0;
		end else if (push) begin
			p1_r <= p0_r;
			p0_r <= push_b;
			if (!pipe_full) pv_r <= pv_r + 2'h1;
		end
	end

	// Payload goes out one byte (ASCII) or two (RTU) behind its arrival; the frame verdict follows at its end.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pay_byte_out   <= '0;
			pay_valid_out  <= 1'b0;
			frame_ok_out   <= 1'b0;
			frame_drop_out <= 1'b0;
		end else begin
			pay_valid_out  <= push && pipe_full && addr_ok; // [R13]
			if (push) pay_byte_out <= emit_b;
			frame_ok_out   <= good; // [R17]
			frame_drop_out <= frame_end && !good; // [R27]
		end
	end

	// ----------------------------------------------------------------
	// Reply sequencer
	// ----------------------------------------------------------------
	logic [7:0]  dly_cnt_r;
	logic [7:0]  tlrc_r;
	logic [15:0] tcrc_r;
	logic [7:0]  cur_r;
	logic        cur_last_r;
	logic        de_r;
	logic [7:0]  chr;
	logic        send;

	wire       can_send = !u_busy && !go_r;
	wire [7:0] lrc_neg  = LRC_GOOD - tlrc_r; // [R16]
	wire       dly_done = ms_tick && (dly_cnt_r == dly_eff - 8'h01); // [R24]

	always_comb begin
		chr    = CHR_CR;
		tx_nxt = tx_st_r;
		send   = 1'b0;
		pop    = 1'b0;
		case (tx_st_r)
			TX_IDLE: if (good) tx_nxt = TX_WAIT; // [R10]
			TX_WAIT: if (dly_done) tx_nxt = is_asc ? TX_SOF : TX_AHI; // [R24]
			TX_SOF: begin
				chr  = CHR_COLON; // [R11]
				send = can_send;
				if (can_send) tx_nxt = TX_AHI;
			end
			TX_AHI: begin
				chr  = is_asc ? hex_enc(addr_r[7:4]) : addr_r; // [R15]
				send = can_send;
				if (can_send) tx_nxt = is_asc ? TX_ALO : TX_DHI;
			end
			TX_ALO: begin
				chr  = hex_enc(addr_r[3:0]); // [R15]
				send = can_send;
				if (can_send) tx_nxt = TX_DHI;
			end
			TX_DHI: begin
				chr  = is_asc ? hex_enc(buf_b[7:4]) : buf_b;
				send = can_send && buf_v;
				pop  = send;
				if (send) tx_nxt = is_asc ? TX_DLO : (buf_last ? TX_CHI : TX_DHI);
			end
			TX_DLO: begin
				chr  = hex_enc(cur_r[3:0]);
				send = can_send;
				if (can_send) tx_nxt = cur_last_r ? TX_CHI : TX_DHI;
			end
			TX_CHI: begin
				chr  = is_asc ? hex_enc(lrc_neg[7:4]) : tcrc_r[7:0]; // [R16] [R20]
				send = can_send;
				if (can_send) tx_nxt = TX_CLO;
			end
			TX_CLO: begin
				chr  = is_asc ? hex_enc(lrc_neg[3:0]) : tcrc_r[15:8]; // [R20]
				send = can_send;
				if (can_send) tx_nxt = is_asc ? TX_CR : TX_END;
			end
			TX_CR: begin
				chr  = CHR_CR; // [R11]
				send = can_send;
				if (can_send) tx_nxt = TX_LF;
			end
			TX_LF: begin
				chr  = CHR_LF; // [R11]
				send = can_send;
				if (can_send) tx_nxt = TX_END;
			end
			TX_END: if (can_send) tx_nxt = TX_IDLE;
			default: tx_nxt = TX_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_st_r   <= TX_IDLE;
			go_r      <= 1'b0;
			chr_r     <= '0;
			dly_cnt_r <= '0;
		end else begin
			tx_st_r   <= tx_nxt;
			go_r      <= send;
			if (send) chr_r <= chr;
			if (tx_st_r != TX_WAIT) dly_cnt_r <= '0;
			else if (ms_tick) dly_cnt_r <= dly_cnt_r + 8'h01; // [R24]
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tlrc_r     <= '0;
			tcrc_r     <= CRC_INIT;
			cur_r      <= '0;
			cur_last_r <= 1'b0;
		end else if (tx_st_r == TX_WAIT) begin
			tlrc_r <= LRC_GOOD;
			tcrc_r <= CRC_INIT;
		end else if (send && tx_st_r == TX_AHI) begin
			tlrc_r <= tlrc_r + addr_r; // [R16]
			tcrc_r <= crc_step(tcrc_r, addr_r); // [R19]
		end else if (pop) begin
			tlrc_r     <= tlrc_r + buf_b; // [R16]
			tcrc_r     <= crc_step(tcrc_r, buf_b); // [R19]
			cur_r      <= buf_b;
			cur_last_r <= buf_last;
		end
	end

	// The driver is enabled only after the delay and released once the last bit is out.
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) de_r <= 1'b0;
		else if (tx_st_r == TX_WAIT && dly_done) de_r <= 1'b1; // [R24]
		else if (tx_st_r == TX_END && can_send) de_r <= 1'b0;
	end

	assign de_out = de_r;
endmodule
`default_nettype wire

// ===== testbench/mbf_props.sv
// Port checker for the framer, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module mbf_props
	import mbf_pkg::*;
#(parameter int unsigned P_MS_CYC = MS_CYC)(
	input wire logic       mclk_in,
	input wire logic       rstn_in,
	input wire logic       txd_out,
	input wire logic       de_out,
	input wire logic [1:0] proto_in,
	input wire logic [6:0] station_number_setting_in,
	input wire logic [7:0] reply_delay_setting_in,
	input wire logic       pay_valid_out,
	input wire logic       frame_ok_out,
	input wire logic       frame_drop_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	// Saturates, so a very late reply cannot wrap and look early.
	logic [23:0] gap_r;
	logic [23:0] dly_w;
	assign dly_w = 24'(reply_delay_setting_in * P_MS_CYC);
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in)
			gap_r <= 24'h0;
		else if (frame_ok_out)
			gap_r <= 24'h0;
		else if (~&gap_r)
			gap_r <= gap_r + 24'h1;
	end
	a_ok_drop_excl: assert property (frame_ok_out |-> !frame_drop_out)
		else $error("good and dropped together");
	a_ok_single: assert property (frame_ok_out |=> !frame_ok_out)
		else $error("good pulse too long");
	a_drop_single: assert property (frame_drop_out |=> !frame_drop_out)
		else $error("drop pulse too long");
	a_zero_silent: assert property (station_number_setting_in == STATION_OFF
		|-> !frame_ok_out) else $error("station zero accepted");
	a_vendor_inert: assert property (proto_in == PROTO_VENDOR
		|-> !(frame_ok_out || pay_valid_out || de_out)) else $error("vendor code active");
	a_reply_delay: assert property ($rose(de_out)
		|-> gap_r + 24'h1 >= dly_w && gap_r <= dly_w + 24'h3) else $error("reply delay");
	a_line_idle: assert property (!de_out |-> txd_out)
		else $error("line moved undriven");
	a_start_lag: assert property ($rose(de_out) |-> txd_out [*2] ##[1:3] !txd_out)
		else $error("no start bit");
	c_ok: cover property (frame_ok_out);
	c_drop: cover property (frame_drop_out);
	c_reply: cover property ($rose(de_out));
endmodule
bind mbf_framer mbf_props #(.P_MS_CYC(P_MS_CYC)) props (.*);
`default_nettype wire

// ===== testbench/mbf_host.sv
// Host master model: frames onto the receive line, replies off the send line.
`timescale 1ns/1ps
`default_nettype none
module mbf_host #(parameter int BC = 32)(
	input  wire logic clk_in,
	input  wire logic txd_in,
	output var logic  rxd_out
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	initial rxd_out = 1'h1;
	// Start, eight data bits low first, stop; idle mark is the line bias.
	task automatic put(logic [7:0] b);
		logic [9:0] w = {1'h1, b, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_in) #2 rxd_out = w[i];
			repeat (BC - 1) @(posedge clk_in);
		end
	endtask
	initial forever begin
		@(negedge txd_in);
		repeat (BC / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (BC) @(posedge clk_in);
			sh = {txd_in, sh[7:1]};
		end
		rx_q.push_back(sh);
		repeat (BC) @(posedge clk_in);
	end
endmodule
`default_nettype wire

// ===== testbench/mbf_framer_tb.sv
// Bench: host frames in, verdicts and replies checked.
`timescale 1ns/1ps
`default_nettype none
module mbf_framer_tb;
	import mbf_pkg::*;
	typedef logic [7:0] mbf_q_t[$];
	logic       mclk_in = 1'h0, rstn_in = 1'h0, len_in = 1'h1, stop_in = 1'h0;
	logic       rep_last_in = 1'h0, rep_valid_in = 1'h0, rxd_in, txd_out, de_out;
	logic       pay_valid_out, frame_ok_out, frame_drop_out, rep_ready_out;
	logic [1:0] proto_in = PROTO_ASCII, baud_in = 2'h0, parity_in = PAR_NONE, vr;
	logic [6:0] station_number_setting_in = 7'h0A;
	logic [7:0] reply_delay_setting_in = 8'h01, rep_byte_in = 8'h83, pay_byte_out;
	int         fail_count = 0, cmp_count = 0;
	mbf_q_t     pq;
	mbf_framer #(.P_BIT_CYC(32), .P_MS_CYC(250)) dut (.*);
	mbf_host #(.BC(32)) host (.clk_in(mclk_in), .txd_in(txd_out), .rxd_out(rxd_in));
	initial forever #12.5 mclk_in = ~mclk_in;
	always @(posedge mclk_in) if ((frame_ok_out | frame_drop_out) === 1'h1)
		vr = {frame_drop_out, frame_ok_out};
	always @(posedge mclk_in) if (pay_valid_out === 1'h1) pq.push_back(pay_byte_out);
	function automatic logic [7:0] hx(logic [3:0] n);
		return n > 4'h9 ? 8'h37 + n : 8'h30 + n;
	endfunction
	function automatic mbf_q_t enc(logic rtu, mbf_q_t f, logic [7:0] bad);
		mbf_q_t w;
		logic [15:0] c = CRC_INIT;
		logic [7:0] s = 8'h00;
		foreach (f[i]) begin
			s -= f[i];
			c ^= 16'(f[i]);
			repeat (8) c = c[0] ? c >> 1 ^ CRC_POLY : c >> 1;
			if (rtu) w.push_back(f[i]);
			else w = {w, hx(f[i][7:4]), hx(f[i][3:0])};
		end
		if (rtu) w = {w, c[7:0] ^ bad, c[15:8]};
		else w = {CHR_COLON, w, hx(s[7:4] ^ bad[3:0]), hx(s[3:0]), CHR_CR, CHR_LF};
		return w;
	endfunction
	task automatic chk(string n, logic [15:0] x, logic [15:0] y);
		cmp_count++;
		if (x !== y) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", n, x, y);
		end
	endtask
	task automatic results;
		$display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// Verdict v is {dropped, good}; only a good frame is answered.
	task automatic run(logic rtu, mbf_q_t f, logic [7:0] bad, logic [1:0] v);
		mbf_q_t w = enc(rtu, f, bad);
		mbf_q_t e = enc(rtu, '{f[0], rep_byte_in}, 8'h00);
		vr = 2'h0;
		host.rx_q.delete();
		pq.delete();
		foreach (w[i]) host.put(w[i]);
		for (int n = 0; n < 6000 && vr === 2'h0; n++) @(posedge mclk_in);
		chk("verdict", v, vr);
		if (v == 2'h1) begin
			foreach (f[i]) if (i > 0) chk("payload", f[i], pq[i - 1]);
			@(posedge mclk_in) #2 {rep_last_in, rep_valid_in} = 2'h3;
			@(posedge mclk_in);
			for (int n = 0; n < 9 && rep_ready_out !== 1'h1; n++) @(posedge mclk_in);
			#2 {rep_last_in, rep_valid_in} = 2'h0;
		end else e.delete();
		for (int n = 0; n < 5000 && (e.size() == 0 || host.rx_q.size() < e.size()); n++)
			@(posedge mclk_in);
		chk("reply length", e.size(), host.rx_q.size());
		foreach (e[i]) chk("reply char", e[i], host.rx_q[i]);
		repeat (2500) @(posedge mclk_in);
		$display("test done, verdict %0d", v);
	endtask
	initial begin
		repeat (16) @(posedge mclk_in);
		#2 rstn_in = 1'h1;
		repeat (4) @(posedge mclk_in);
		run(0, '{8'h0A, 8'h03, 8'h00, 8'h02}, 8'h00, 2'h1);
		run(0, '{8'h0A, 8'h03, 8'h00, 8'h02}, 8'h01, 2'h2);
		run(0, '{8'h0B, 8'h03}, 8'h00, 2'h2);
		host.put(CHR_COLON);
		host.put(8'h30);
		run(0, '{8'h0A, 8'h10}, 8'h00, 2'h1);
		#2 station_number_setting_in = STATION_OFF;
		run(0, '{8'h00, 8'h03}, 8'h00, 2'h2);
		#2 {proto_in, len_in} = {PROTO_RTU, 1'h0};
		station_number_setting_in = 7'h0A;
		reply_delay_setting_in = 8'h02;
		run(1, '{8'h0A, 8'h03, 8'h03, 8'hE9, 8'h00, 8'h02}, 8'h00, 2'h1);
		run(1, '{8'h0A, 8'h03}, 8'h01, 2'h2);
		#2 proto_in = PROTO_VENDOR;
		run(0, '{8'h0A, 8'h03}, 8'h00, 2'h0);
		results;
	end
	initial begin
		repeat (99000) @(posedge mclk_in);
		fail_count++;
		results;
	end
endmodule
`default_nettype wire
